// ==== src/usbsp_params.svh ====
// Purpose: constants of the usb sleep and pin-function block
// Assumes: 32-bit register words at byte addresses
// Notes: field positions are bit numbers inside a register word
`ifndef USBSP_PARAMS_SVH
`define USBSP_PARAMS_SVH
// register byte offsets
`define USBSP_OFF_CFG 8'h00
`define USBSP_OFF_CTRL 8'h04
`define USBSP_OFF_STAT 8'h08
`define USBSP_OFF_ISTAT 8'h0c
`define USBSP_OFF_IMASK 8'h10
// config_store fields
`define USBSP_CFG_ENH_MODEM 0
`define USBSP_CFG_STD_MODEM 1
`define USBSP_CFG_SLEEP_HI 2
`define USBSP_CFG_LVL0 3
`define USBSP_CFG_LVL1 4
`define USBSP_CFG_OD0 5
`define USBSP_CFG_OD1 6
`define USBSP_CFG_W 7
// control fields
`define USBSP_CTL_TRDY 0
`define USBSP_CTL_RTS 1
`define USBSP_CTL_DIR0 2
`define USBSP_CTL_DIR1 3
`define USBSP_CTL_VAL0 4
`define USBSP_CTL_VAL1 5
`define USBSP_CTL_OD0 6
`define USBSP_CTL_OD1 7
// interrupt bits
`define USBSP_IRQ_SLEEP 0
`define USBSP_IRQ_WAKE 1
`define USBSP_IRQ_RING 2
`define USBSP_IRQ_DCD 3
`define USBSP_IRQ_W 4
// reset values, factory config is user-pin mode
`define USBSP_CFG_RST 7'h00
`define USBSP_CTRL_RST 8'h00
`define USBSP_IRQ_RST 4'h0
// bus answers
`define USBSP_RESP_OK 2'b00
`define USBSP_RESP_DEC 2'b11
`endif

// ==== src/usbsp_pkg.sv ====
// Purpose: state types of the usb sleep and pin-function block
// Assumes: constants come from the params header
// Notes: each module keeps all its state in one of these structs
`include "usbsp_params.svh"
package usbsp_pkg;
    typedef enum logic [1:0] {SUS_CFG, SUS_RUN, SUS_SLEEP} usbsp_sus_t;
    typedef struct packed {
        usbsp_sus_t st;
        logic cfgd;
        logic enter;
        logic leave;
    } usbsp_sus_state_t;
    typedef struct packed {
        logic o;
        logic oe;
    } usbsp_pad_state_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [`USBSP_CFG_W-1:0] cfg;
        logic cfg_lock;
        logic [7:0] ctrl;
        logic [`USBSP_IRQ_W-1:0] istat;
        logic [`USBSP_IRQ_W-1:0] imask;
        logic irq;
        logic ring_prev;
        logic dcd_prev;
        logic tx;
        logic rx;
        logic rts;
    } usbsp_top_state_t;
endpackage

// ==== src/usbsp_pad.sv ====
// Purpose: registered driver of one two-way pin
// Assumes: drive, level and mode come from flops or stable logic
// Notes: open-drain high releases the pin to the external pull
`timescale 1ns/10ps
module usbsp_pad (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // drive request
    input wire logic drive,
    input wire logic level,
    input wire logic open_drain,
    // pin side
    output logic pad_o,
    output logic pad_oe
);
    usbsp_pkg::usbsp_pad_state_t s_q;
    usbsp_pkg::usbsp_pad_state_t s_d;

    // high on open-drain is a released pin, not a driven one
    always_comb
    begin
        s_d.o = level;
        s_d.oe = drive && !(open_drain && level);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pad_o = s_q.o;
    assign pad_oe = s_q.oe;

    reset_float_a: assert property (
        @(posedge aclk) !aresetn |=> !pad_oe)
        else $error("pin driven after a reset edge");
endmodule // usbsp_pad

// ==== src/usbsp_susp.sv ====
// Purpose: usb suspend state of the function controller
// Assumes: detector inputs are one-cycle or level events on aclk
// Notes: wake has priority over a suspend seen in the same cycle
`timescale 1ns/10ps
module usbsp_susp (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus events
    input wire logic suspend_det,
    input wire logic resume_det,
    input wire logic bus_reset_det,
    input wire logic enum_done,
    // state
    output logic sleep_q,
    output logic suspended_q,
    output logic configured_q,
    output logic enter_q,
    output logic leave_q
);
    usbsp_pkg::usbsp_sus_state_t s_q;
    usbsp_pkg::usbsp_sus_state_t s_d;
    logic wake;

    assign wake = resume_det || bus_reset_det;

    // suspend sequencing
    always_comb
    begin
        s_d = s_q;
        s_d.enter = 1'b0;
        s_d.leave = 1'b0;
        if (enum_done)
            s_d.cfgd = 1'b1;
        case (s_q.st)
            usbsp_pkg::SUS_CFG, usbsp_pkg::SUS_RUN:
            begin
                if (suspend_det && !wake)
                begin
                    s_d.st = usbsp_pkg::SUS_SLEEP;
                    s_d.enter = 1'b1;
                end
                else if (s_d.cfgd)
                    s_d.st = usbsp_pkg::SUS_RUN;
            end
            usbsp_pkg::SUS_SLEEP:
            begin
                if (wake)
                begin
                    s_d.st = s_d.cfgd ? usbsp_pkg::SUS_RUN
                                      : usbsp_pkg::SUS_CFG;
                    s_d.leave = 1'b1;
                end
            end
            default: s_d.st = usbsp_pkg::SUS_CFG;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '{usbsp_pkg::SUS_CFG, 1'b0, 1'b0, 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sleep_q = s_q.st != usbsp_pkg::SUS_RUN;
    assign suspended_q = s_q.st == usbsp_pkg::SUS_SLEEP;
    assign configured_q = s_q.cfgd;
    assign enter_q = s_q.enter;
    assign leave_q = s_q.leave;

    enter_sleep_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        suspend_det && !wake |=> suspended_q && s_q.st != $past(s_q.st)
            || $past(suspended_q))
        else $error("suspend detect did not enter suspend");
    leave_sleep_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        suspended_q && wake |=> !suspended_q && leave_q)
        else $error("wake did not leave suspend");
    hold_unconf_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !enum_done && !s_q.cfgd |=> sleep_q)
        else $error("indicator dropped before enumeration");
endmodule // usbsp_susp

// ==== src/usbsp_top.sv ====
// Purpose: usb suspend handling and pin-function control, axi4-lite
// Assumes: pin and event inputs synchronous to aclk
// Notes: the uart core sits outside, on uart_tx_enh and uart_rx_enh
`timescale 1ns/10ps
`include "usbsp_params.svh"
module usbsp_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // usb function events
    input wire logic usb_suspend_det,
    input wire logic usb_resume_det,
    input wire logic usb_bus_reset_det,
    input wire logic enum_done,
    input wire logic prog_supply_ok,
    // enhanced_port stream to the uart core
    input wire logic uart_tx_enh,
    output logic uart_rx_enh,
    // enhanced_port serial and flow pins
    output logic serial_out_enh,
    input wire logic serial_in_enh,
    output logic request_send_out_enh,
    input wire logic clear_send_in_enh,
    input wire logic carrier_detect_in_enh,
    // enhanced_port shared pins
    input wire logic user_pin0_enh_i,
    output logic user_pin0_enh_o,
    output logic user_pin0_enh_oe,
    input wire logic user_pin1_enh_i,
    output logic user_pin1_enh_o,
    output logic user_pin1_enh_oe,
    input wire logic bus_sleep_indicator_enh_i,
    output logic bus_sleep_indicator_enh_o,
    output logic bus_sleep_indicator_enh_oe,
    // standard_port pins
    input wire logic clear_send_in_std,
    input wire logic bus_sleep_indicator_std_i,
    output logic bus_sleep_indicator_std_o,
    output logic bus_sleep_indicator_std_oe,
    // interrupt
    output logic irq
);
    usbsp_pkg::usbsp_top_state_t s_q;
    usbsp_pkg::usbsp_top_state_t s_d;
    logic sleep_w;
    logic suspended_w;
    logic configured_w;
    logic sus_enter;
    logic sus_leave;
    logic modem_e;
    logic modem_s;
    logic ring_now;
    logic ring_std;
    logic dcd_now;
    logic dsr_now;
    logic [31:0] stat_w;
    logic [`USBSP_IRQ_W-1:0] ev;
    logic [`USBSP_IRQ_W-1:0] w1c;
    logic drv0;
    logic lvl0;
    logic od0;
    logic drv1;
    logic lvl1;
    logic od1;

    // address decode shared by both channels
    function automatic logic map_hit(input logic [7:0] a);
        map_hit = a == `USBSP_OFF_CFG || a == `USBSP_OFF_CTRL ||
            a == `USBSP_OFF_STAT || a == `USBSP_OFF_ISTAT ||
            a == `USBSP_OFF_IMASK;
    endfunction

    usbsp_susp u_susp (
        .aclk(aclk),
        .aresetn(aresetn),
        .suspend_det(usb_suspend_det),
        .resume_det(usb_resume_det),
        .bus_reset_det(usb_bus_reset_det),
        .enum_done(enum_done),
        .sleep_q(sleep_w),
        .suspended_q(suspended_w),
        .configured_q(configured_w),
        .enter_q(sus_enter),
        .leave_q(sus_leave)
    );

    assign modem_e = s_q.cfg[`USBSP_CFG_ENH_MODEM];
    assign modem_s = s_q.cfg[`USBSP_CFG_STD_MODEM];

    assign dsr_now = modem_e && !user_pin1_enh_i;
    assign ring_now = modem_e && !bus_sleep_indicator_enh_i;
    assign ring_std = modem_s && !bus_sleep_indicator_std_i;
    assign dcd_now = modem_e && !carrier_detect_in_enh;

    assign stat_w = {21'h00_0000, user_pin1_enh_i, user_pin0_enh_i,
        !clear_send_in_std, !clear_send_in_enh, ring_std, ring_now,
        dcd_now, dsr_now, s_q.cfg_lock, configured_w, suspended_w};

    assign drv0 = modem_e || suspended_w || s_q.ctrl[`USBSP_CTL_DIR0];
    assign drv1 = !modem_e &&
        (suspended_w || s_q.ctrl[`USBSP_CTL_DIR1]);
    assign od0 = !modem_e && (suspended_w ? s_q.cfg[`USBSP_CFG_OD0]
                                          : s_q.ctrl[`USBSP_CTL_OD0]);
    assign od1 = suspended_w ? s_q.cfg[`USBSP_CFG_OD1]
                             : s_q.ctrl[`USBSP_CTL_OD1];
    assign lvl1 = suspended_w ? s_q.cfg[`USBSP_CFG_LVL1]
                              : s_q.ctrl[`USBSP_CTL_VAL1];

    always_comb
    begin
        if (modem_e)
            lvl0 = !s_q.ctrl[`USBSP_CTL_TRDY];
        else if (suspended_w)
            lvl0 = s_q.cfg[`USBSP_CFG_LVL0];
        else
            lvl0 = s_q.ctrl[`USBSP_CTL_VAL0];
    end

    // user pin 0 or terminal ready
    usbsp_pad u_pin0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .drive(drv0),
        .level(lvl0),
        .open_drain(od0),
        .pad_o(user_pin0_enh_o),
        .pad_oe(user_pin0_enh_oe)
    );

    // user pin 1, input in modem mode
    usbsp_pad u_pin1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .drive(drv1),
        .level(lvl1),
        .open_drain(od1),
        .pad_o(user_pin1_enh_o),
        .pad_oe(user_pin1_enh_oe)
    );

    usbsp_pad u_sleep_enh (
        .aclk(aclk),
        .aresetn(aresetn),
        .drive(!modem_e),
        .level(sleep_w == s_q.cfg[`USBSP_CFG_SLEEP_HI]),
        .open_drain(1'b0),
        .pad_o(bus_sleep_indicator_enh_o),
        .pad_oe(bus_sleep_indicator_enh_oe)
    );

    usbsp_pad u_sleep_std (
        .aclk(aclk),
        .aresetn(aresetn),
        .drive(!modem_s),
        .level(sleep_w == s_q.cfg[`USBSP_CFG_SLEEP_HI]),
        .open_drain(1'b0),
        .pad_o(bus_sleep_indicator_std_o),
        .pad_oe(bus_sleep_indicator_std_oe)
    );

    // interrupt sources: enter, leave, ring edge, carrier change
    assign ev = {dcd_now != s_q.dcd_prev, ring_now && !s_q.ring_prev,
        sus_leave, sus_enter};

    // host requests over the register bus
    always_comb
    begin
        s_d = s_q;
        w1c = '0;
        if (s_axi_bready)
            s_d.bvalid = 1'b0;
        if (s_axi_rready)
            s_d.rvalid = 1'b0;
        // address and data may come in either order
        if (s_axi_awvalid && s_q.awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb0 = s_axi_wstrb[0];
        end
        if (s_d.aw_got && s_d.w_got && !s_d.bvalid)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = map_hit(s_d.awaddr) ? `USBSP_RESP_OK
                                            : `USBSP_RESP_DEC;
            // all fields live in byte lane 0
            if (s_d.wstrb0)
            begin
                case (s_d.awaddr)
                    `USBSP_OFF_CFG:
                    begin
                        if (prog_supply_ok && !s_q.cfg_lock)
                        begin
                            s_d.cfg = s_d.wdata[`USBSP_CFG_W-1:0];
                            s_d.cfg_lock = 1'b1;
                        end
                    end
                    `USBSP_OFF_CTRL: s_d.ctrl = s_d.wdata[7:0];
                    `USBSP_OFF_ISTAT: w1c = s_d.wdata[`USBSP_IRQ_W-1:0];
                    `USBSP_OFF_IMASK:
                        s_d.imask = s_d.wdata[`USBSP_IRQ_W-1:0];
                    default: w1c = '0;
                endcase
            end
        end
        // one read in flight, answered one edge after acceptance
        if (s_axi_arvalid && s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = map_hit(s_axi_araddr) ? `USBSP_RESP_OK
                                              : `USBSP_RESP_DEC;
            case (s_axi_araddr)
                `USBSP_OFF_CFG: s_d.rdata = {25'h000_0000, s_q.cfg};
                `USBSP_OFF_CTRL: s_d.rdata = {24'h00_0000, s_q.ctrl};
                `USBSP_OFF_STAT: s_d.rdata = stat_w;
                `USBSP_OFF_ISTAT: s_d.rdata = {28'h000_0000, s_q.istat};
                `USBSP_OFF_IMASK: s_d.rdata = {28'h000_0000, s_q.imask};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // a new event beats a clear in the same cycle
        s_d.istat = (s_q.istat & ~w1c) | ev;
        s_d.irq = |(s_d.istat & s_d.imask);
        s_d.ring_prev = ring_now;
        s_d.dcd_prev = dcd_now;
        // serial streams pass through one flop each way
        s_d.tx = uart_tx_enh;
        s_d.rx = serial_in_enh;
        s_d.rts = !s_d.ctrl[`USBSP_CTL_RTS];
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.cfg <= `USBSP_CFG_RST;
            s_q.ctrl <= `USBSP_CTRL_RST;
            s_q.imask <= `USBSP_IRQ_RST;
            s_q.tx <= 1'b1;
            s_q.rx <= 1'b1;
            s_q.rts <= 1'b1; // idle lines high
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign serial_out_enh = s_q.tx;
    assign uart_rx_enh = s_q.rx;
    assign request_send_out_enh = s_q.rts;
    assign irq = s_q.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sleep_assert_a: assert property (
        $past(aresetn) && $past(sleep_w && !modem_e) |->
        bus_sleep_indicator_enh_oe &&
        bus_sleep_indicator_enh_o == $past(s_q.cfg[`USBSP_CFG_SLEEP_HI]))
        else $error("sleep indicator not at active level");
    sleep_release_a: assert property (
        $past(aresetn) && $past(!sleep_w && !modem_s) |->
        bus_sleep_indicator_std_oe &&
        bus_sleep_indicator_std_o != $past(s_q.cfg[`USBSP_CFG_SLEEP_HI]))
        else $error("sleep indicator not released after wake");
    ring_keep_a: assert property (
        $past(aresetn) && $past(modem_e) |-> !bus_sleep_indicator_enh_oe)
        else $error("ring pin driven in modem mode");
    trdy_drive_a: assert property (
        $past(aresetn) && $past(modem_e) |-> user_pin0_enh_oe &&
        user_pin0_enh_o == !$past(s_q.ctrl[`USBSP_CTL_TRDY]))
        else $error("terminal ready not driven active low");
    susp_level_a: assert property (
        $past(aresetn) && $past(suspended_w && !modem_e) |->
        user_pin1_enh_o == $past(s_q.cfg[`USBSP_CFG_LVL1]))
        else $error("suspend pin level not from config");
    rts_low_a: assert property (
        $rose(s_q.ctrl[`USBSP_CTL_RTS]) |-> !request_send_out_enh)
        else $error("request to send not low when asserted");
    cfg_guard_a: assert property (
        !prog_supply_ok || s_q.cfg_lock |=> $stable(s_q.cfg))
        else $error("config changed without programming supply");
    irq_set_a: assert property (
        sus_enter && s_q.imask[`USBSP_IRQ_SLEEP] |=>
        s_q.istat[`USBSP_IRQ_SLEEP] && irq)
        else $error("suspend event lost from interrupt");

    enter_c: cover property (sus_enter);
    leave_c: cover property (sus_leave ##1 irq);
    ring_c: cover property (ev[`USBSP_IRQ_RING]);
    decerr_c: cover property (s_axi_bvalid &&
        s_axi_bresp == `USBSP_RESP_DEC);
endmodule // usbsp_top

// ==== test/usbsp_peer.sv ====
// Purpose: far side of the pins, a modem peer and the pin pulls
// Assumes: oe high while the block drives a pin
// Notes: ctl_on asserts every peer modem signal at once, except the standard_port indicator, which stays pulled up
`timescale 1ns/10ps
module usbsp_peer (
    // pad drive from the block
    input wire logic user_pin0_enh_o, user_pin0_enh_oe,
    input wire logic user_pin1_enh_o, user_pin1_enh_oe,
    input wire logic bus_sleep_indicator_enh_o, bus_sleep_indicator_enh_oe,
    input wire logic bus_sleep_indicator_std_o, bus_sleep_indicator_std_oe,
    // peer modem request
    input wire logic ctl_on,
    // resolved pin levels
    output logic user_pin0_enh_i, user_pin1_enh_i,
    output logic bus_sleep_indicator_enh_i, bus_sleep_indicator_std_i,
    output logic carrier_detect_in_enh, clear_send_in_enh,
    output logic clear_send_in_std
);
    // released indicators float to pull-up, ring peer pulls only the enhanced_port one low
    assign bus_sleep_indicator_enh_i =
        bus_sleep_indicator_enh_oe ? bus_sleep_indicator_enh_o : ~ctl_on;
    assign bus_sleep_indicator_std_i =
        bus_sleep_indicator_std_oe ? bus_sleep_indicator_std_o : 1'b1;
    // shared pins: the peer drives them only when the block lets go
    assign user_pin0_enh_i = user_pin0_enh_oe ? user_pin0_enh_o : ~ctl_on;
    assign user_pin1_enh_i = user_pin1_enh_oe ? user_pin1_enh_o : ~ctl_on;
    assign carrier_detect_in_enh = ~ctl_on;
    assign clear_send_in_enh = ~ctl_on;
    assign clear_send_in_std = ~ctl_on;
endmodule // usbsp_peer

// ==== test/tb.sv ====
// Purpose: self-checking bench of the sleep and pin-function block
// Assumes: axi4-lite master tasks, peer model on the pins
// Notes: pad effects land two edges after their cause
`timescale 1ns/10ps
`include "usbsp_params.svh"
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, ctl_on;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic usb_suspend_det, usb_resume_det, usb_bus_reset_det, enum_done;
    logic prog_supply_ok, uart_tx_enh, uart_rx_enh, serial_out_enh;
    logic serial_in_enh, request_send_out_enh, clear_send_in_enh;
    logic carrier_detect_in_enh, clear_send_in_std;
    logic user_pin0_enh_i, user_pin0_enh_o, user_pin0_enh_oe;
    logic user_pin1_enh_i, user_pin1_enh_o, user_pin1_enh_oe;
    logic bus_sleep_indicator_enh_i, bus_sleep_indicator_enh_o;
    logic bus_sleep_indicator_enh_oe, bus_sleep_indicator_std_i;
    logic bus_sleep_indicator_std_o, bus_sleep_indicator_std_oe;
    int err_total, num_checks;

    usbsp_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .usb_suspend_det,
        .usb_resume_det, .usb_bus_reset_det, .enum_done, .prog_supply_ok,
        .uart_tx_enh, .uart_rx_enh, .serial_out_enh, .serial_in_enh,
        .request_send_out_enh, .clear_send_in_enh, .carrier_detect_in_enh,
        .user_pin0_enh_i, .user_pin0_enh_o, .user_pin0_enh_oe,
        .user_pin1_enh_i, .user_pin1_enh_o, .user_pin1_enh_oe,
        .bus_sleep_indicator_enh_i, .bus_sleep_indicator_enh_o,
        .bus_sleep_indicator_enh_oe, .clear_send_in_std,
        .bus_sleep_indicator_std_i, .bus_sleep_indicator_std_o,
        .bus_sleep_indicator_std_oe, .irq);

    usbsp_peer peer (.user_pin0_enh_o, .user_pin0_enh_oe, .user_pin1_enh_o,
        .user_pin1_enh_oe, .bus_sleep_indicator_enh_o,
        .bus_sleep_indicator_enh_oe, .bus_sleep_indicator_std_o,
        .bus_sleep_indicator_std_oe, .ctl_on, .user_pin0_enh_i,
        .user_pin1_enh_i, .bus_sleep_indicator_enh_i,
        .bus_sleep_indicator_std_i, .carrier_detect_in_enh,
        .clear_send_in_enh, .clear_send_in_std);

    // 10 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    // write; two spare edges so pad effects have landed on return
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        logic [1:0] er;
        done = 1'b0;
        // offsets past the mask register are unmapped
        er = (a > `USBSP_OFF_IMASK) ? `USBSP_RESP_DEC : `USBSP_RESP_OK;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                s_axi_bready <= 1'b0;
                done = 1'b1;
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
            end
        end
        repeat (2) @(posedge aclk);
    endtask

    // read and compare the masked word and the response
    task automatic rd(input logic [7:0] a, input logic [1:0] er,
                      input logic [31:0] m, input logic [31:0] e);
        logic done;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                s_axi_rready <= 1'b0;
                rd_q = s_axi_rdata;
                done = 1'b1;
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                chk($sformatf("reg %h", a), e, rd_q & m);
            end
        end
        // spare edge so a following read never retouches rready
        @(posedge aclk);
    endtask

    // one-cycle usb event: 0 sleep, 1 resume, 2 bus reset, 3 enumerated
    task automatic ev(input int k);
        case (k)
            0: usb_suspend_det <= 1'b1;
            1: usb_resume_det <= 1'b1;
            2: usb_bus_reset_det <= 1'b1;
            default: enum_done <= 1'b1;
        endcase
        @(posedge aclk);
        {usb_suspend_det, usb_resume_det, usb_bus_reset_det} <= 3'b000;
        enum_done <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard, far beyond the roughly 120 cycles of the tests
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_total++;
        results();
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, ctl_on, prog_supply_ok} = 4'h0;
        {usb_suspend_det, usb_resume_det, usb_bus_reset_det} = 3'b000;
        enum_done = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {uart_tx_enh, serial_in_enh} = 2'b11;
        repeat (16) @(posedge aclk);
        chk("ind_oe", 0, bus_sleep_indicator_enh_oe);
        chk("ind_pull", 1, bus_sleep_indicator_enh_i);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("ind_hold", 0, bus_sleep_indicator_enh_i);
        rd(`USBSP_OFF_CFG, `USBSP_RESP_OK, 32'hff, 0);
        rd(8'h14, `USBSP_RESP_DEC, 32'hffff_ffff, 0);
        wr(8'h14, 32'hff);
        wr(`USBSP_OFF_IMASK, 32'h3);
        ev(3);
        chk("ind_run", 1, bus_sleep_indicator_enh_i);
        wr(`USBSP_OFF_CTRL, 32'h14);
        chk("pin0", 1, user_pin0_enh_i);
        ctl_on <= 1'b1;
        rd(`USBSP_OFF_STAT, `USBSP_RESP_OK, 32'h10, 0);
        // each wake source in turn, with interrupt clear between
        for (int k = 1; k < 3; k++)
        begin
            ev(0);
            chk("ind_sus", 0, bus_sleep_indicator_enh_i);
            chk("std_sus", 0, bus_sleep_indicator_std_i);
            chk("pin0_sus", 0, user_pin0_enh_i);
            chk("pin1_sus", 1, user_pin1_enh_oe);
            chk("irq", 1, irq);
            rd(`USBSP_OFF_STAT, `USBSP_RESP_OK, 32'h1, 32'h1);
            wr(`USBSP_OFF_ISTAT, 32'h3);
            chk("irq_clr", 0, irq);
            ev(k);
            chk("ind_wake", 1, bus_sleep_indicator_enh_i);
            rd(`USBSP_OFF_ISTAT, `USBSP_RESP_OK, 32'h3, 32'h2);
            wr(`USBSP_OFF_ISTAT, 32'h2);
        end
        wr(`USBSP_OFF_CFG, 32'h5);
        rd(`USBSP_OFF_CFG, `USBSP_RESP_OK, 32'hff, 0);
        prog_supply_ok <= 1'b1;
        wr(`USBSP_OFF_CFG, 32'h5);
        rd(`USBSP_OFF_CFG, `USBSP_RESP_OK, 32'hff, 32'h5);
        chk("std_hi_run", 0, bus_sleep_indicator_std_i);
        ev(0);
        chk("std_hi_sus", 1, bus_sleep_indicator_std_i);
        chk("enh_ring", 0, bus_sleep_indicator_enh_oe);
        ev(1);
        chk("std_hi_wake", 0, bus_sleep_indicator_std_i);
        wr(`USBSP_OFF_CTRL, 32'h3);
        chk("trdy_o", 0, user_pin0_enh_o);
        chk("trdy_oe", 1, user_pin0_enh_oe);
        chk("rts", 0, request_send_out_enh);
        rd(`USBSP_OFF_STAT, `USBSP_RESP_OK, 32'h1b8, 32'h1b8);
        rd(`USBSP_OFF_ISTAT, `USBSP_RESP_OK, 32'h4, 32'h4);
        {uart_tx_enh, serial_in_enh} <= 2'b00;
        repeat (2) @(posedge aclk);
        chk("txd", 0, serial_out_enh);
        chk("rxd", 0, uart_rx_enh);
        results();
    end
endmodule // tb
